// ---- src/pllpc_top.sv ----
// Top: three phase detectors, lock pulse and oscillator gating
// Function
// - XOR output high when inputs differ
// - XOR output ripples at twice input frequency
// - Edge detector reacts to rising edges only
// - Two flops: signal counts up, comparator down
// - Signal leading: drive high for phase gap
// - Signal lagging: drive low for phase gap
// - Signal faster: mostly high, rest tristate
// - Signal slower: mostly low
// - Locked: tristate output, lock pulse high
// - No signal: edge detector drives oscillator down
// - Set/reset detector on rising edges only
// - Set/reset detector spans full cycle phase
// - No signal: set/reset detector drives down
// - Disable high stops oscillator, low enables
// - Oscillator duty cycle held at one half
`timescale 1ns/1ps
`default_nettype none
module pllpc_top #(
  parameter int OSC_W = pllpc_pkg::OSC_CNT_W
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  input  wire logic             reference_signal_in_i,
  input  wire logic             comparator_in_i,
  input  wire logic             oscillator_disable_i,
  input  wire logic [OSC_W-1:0] oscillator_control_in_i,
  output logic                  xor_detector_out_o,
  output logic                  edge_detector_tristate_out_o,
  output logic                  edge_detector_tristate_oe_o,
  output logic                  setreset_detector_out_o,
  output logic                  lock_pulse_out_o,
  output logic                  oscillator_out_o
);
  // Pump states of the edge detector; one flop per direction
  typedef enum logic [1:0] {
    PUMP_IDLE = 2'b00,
    PUMP_UP   = 2'b01,
    PUMP_DN   = 2'b10
  } pllpc_pump_e;

  // Rise seen when the pin is high now and was low one edge ago
  function automatic logic rise_of(
    input logic now_lvl,
    input logic last_lvl
  );
    return now_lvl & ~last_lvl;
  endfunction : rise_of

  // Any pump state but idle drives the pin
  function automatic logic drives_pin(
    input pllpc_pump_e state
  );
    return state != PUMP_IDLE;
  endfunction : drives_pin

  // Input history for rising-edge detection
  logic        sig_q;
  logic        cmp_q;
  logic        next_sig_q;
  logic        next_cmp_q;
  logic        sig_rise;
  logic        cmp_rise;

  // Exclusive-or detector
  logic        xo;
  logic        next_xo;

  // Edge-frequency detector state and registered pin stage
  pllpc_pump_e pump;
  pllpc_pump_e next_pump;
  logic        pd;
  logic        next_pd;
  logic        oe;
  logic        next_oe;
  logic        lk;
  logic        next_lk;

  // Set/reset detector
  logic        sr;
  logic        next_sr;

  // Rising edges only; input duty cycle has no effect here
  assign sig_rise = rise_of(reference_signal_in_i, sig_q);
  assign cmp_rise = rise_of(comparator_in_i, cmp_q);

  // Next input history: plain copy of the pins
  always_comb begin
    next_sig_q = reference_signal_in_i;
    next_cmp_q = comparator_in_i;
  end

  // Reset low, so a pin already high at release counts as a rise
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sig_q <= pllpc_pkg::RST_SIG_Q;
      cmp_q <= pllpc_pkg::RST_CMP_Q;
    end else begin
      sig_q <= next_sig_q;
      cmp_q <= next_cmp_q;
    end
  end

  // Level difference; toggles on both edges of either pin
  always_comb begin
    next_xo = reference_signal_in_i ^ comparator_in_i;
  end

  // Registered so the pin comes straight from a flop
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xo <= pllpc_pkg::RST_XOR;
    end else begin
      xo <= next_xo;
    end
  end

  // Up-down counter: signal rise counts up, comparator rise down
  always_comb begin
    next_pump = pump;
    unique case (pump)
      PUMP_IDLE: begin
        if (sig_rise && !cmp_rise) begin
          next_pump = PUMP_UP;
        end else if (cmp_rise && !sig_rise) begin
          next_pump = PUMP_DN;
        end else begin
          next_pump = PUMP_IDLE;  // Rises on both pins cancel
        end
      end
      PUMP_UP: begin
        // Further signal rises saturate; a comparator rise sets the
        // second flop and both set clears both at once
        if (cmp_rise) begin
          next_pump = PUMP_IDLE;
        end else begin
          next_pump = PUMP_UP;
        end
      end
      PUMP_DN: begin
        // Without signal rises this never leaves: loop pulled low
        if (sig_rise) begin
          next_pump = PUMP_IDLE;
        end else begin
          next_pump = PUMP_DN;
        end
      end
      default: begin
        // Both flops set is never held; clear as the gating would
        next_pump = PUMP_IDLE;
      end
    endcase
  end

  // Pump flops; both clear after reset
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pump <= pllpc_pump_e'({pllpc_pkg::RST_DN, pllpc_pkg::RST_UP});
    end else begin
      pump <= next_pump;
    end
  end

  // Pin stage follows the pump: up high, down low, idle floats
  always_comb begin
    next_pd = (next_pump == PUMP_UP);
    next_oe = drives_pin(next_pump);
    // Lock is a level here, high whenever no correction is driven
    next_lk = ~drives_pin(next_pump);
  end

  // Registered pin stage keeps the pump pins glitch free
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pd <= pllpc_pkg::RST_DRIVE;
      oe <= pllpc_pkg::RST_OE;
      lk <= pllpc_pkg::RST_LOCK;
    end else begin
      pd <= next_pd;
      oe <= next_oe;
      lk <= next_lk;
    end
  end

  // Set by signal, cleared by comparator; the set wins a tie so a
  // lost set cannot pull the loop toward the low end
  always_comb begin
    next_sr = sr;
    if (cmp_rise) begin
      next_sr = 1'b0;
    end
    if (sig_rise) begin
      next_sr = 1'b1;
    end
  end

  // Set/reset flop; low after reset like an idle loop
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sr <= pllpc_pkg::RST_SR;
    end else begin
      sr <= next_sr;
    end
  end

  // Every detector pin comes straight from its flop
  assign xor_detector_out_o           = xo;
  assign edge_detector_tristate_out_o = pd;
  assign edge_detector_tristate_oe_o  = oe;
  assign lock_pulse_out_o             = lk;
  assign setreset_detector_out_o      = sr;

  // Oscillator output is registered inside; loop closes outside
  pllpc_osc #(
    .W(OSC_W)
  ) u_osc (
    .clk_sys_i            (clk_sys_i),
    .rstn_i               (rstn_i),
    .oscillator_disable_i (oscillator_disable_i),
    .oscillator_control_i (oscillator_control_in_i),
    .oscillator_o         (oscillator_out_o)
  );
endmodule : pllpc_top
`default_nettype wire

// ---- src/pllpc_pkg.sv ----
// Package: constants for the PLL phase-comparator block
`default_nettype none
package pllpc_pkg;
  // Reset values of detector state
  localparam logic RST_UP        = 1'b0;
  localparam logic RST_DN        = 1'b0;
  localparam logic RST_SR        = 1'b0;
  localparam logic RST_SIG_Q     = 1'b0;
  localparam logic RST_CMP_Q     = 1'b0;
  localparam logic RST_LOCK      = 1'b1;
  localparam logic RST_XOR       = 1'b0;
  localparam logic RST_DRIVE     = 1'b0;
  localparam logic RST_OE        = 1'b0;
  // Oscillator divider defaults: half period in system clock cycles, counter width in bits
  localparam int   OSC_HALF_DEF  = 50;
  localparam int   OSC_CNT_W     = 16;
  localparam logic [15:0] OSC_CNT_RST = 16'h0000;
  // Oscillator output level after reset and while disabled
  localparam logic RST_OSC       = 1'b0;
endpackage : pllpc_pkg
`default_nettype wire

// ---- src/pllpc_osc.sv ----
// Oscillator model: numeric control word sets the half period
`timescale 1ns/1ps
`default_nettype none
module pllpc_osc #(
  parameter int W = pllpc_pkg::OSC_CNT_W
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rstn_i,
  input  wire logic         oscillator_disable_i,
  input  wire logic [W-1:0] oscillator_control_i,
  output logic              oscillator_o
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         osc;
  logic         next_osc;
  logic [W-1:0] half;

  // Zero control would stall; clamp to one cycle per half period
  assign half = (oscillator_control_i == '0) ? W'(1) : oscillator_control_i;

  // Equal high and low halves keep the duty cycle at one half
  always_comb begin
    next_cnt = cnt;
    next_osc = osc;
    if (oscillator_disable_i) begin
      next_cnt = '0;
      next_osc = pllpc_pkg::RST_OSC;
    end else if (cnt >= half - W'(1)) begin
      next_cnt = '0;
      next_osc = ~osc;
    end else begin
      next_cnt = cnt + W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= W'(pllpc_pkg::OSC_CNT_RST);
      osc <= pllpc_pkg::RST_OSC;
    end else begin
      cnt <= next_cnt;
      osc <= next_osc;
    end
  end

  assign oscillator_o = osc;
endmodule : pllpc_osc
`default_nettype wire

// ---- testbench/pllpc_chk_sva.sv ----
// Checker: detector timing relations at top ports
`timescale 1ns/1ps
`default_nettype none
module pllpc_chk (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic reference_signal_in_i,
  input wire logic comparator_in_i,
  input wire logic xor_detector_out_o,
  input wire logic edge_detector_tristate_out_o,
  input wire logic edge_detector_tristate_oe_o,
  input wire logic setreset_detector_out_o,
  input wire logic lock_pulse_out_o
);
  logic pr, pc;
  wire ru = reference_signal_in_i & ~pr;
  wire cu = comparator_in_i & ~pc;
  wire oe = edge_detector_tristate_oe_o;
  wire pd = edge_detector_tristate_out_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // Last samples, low from reset so a high input counts as a rise
  always_ff @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i) {pr, pc} <= 2'b00;
    else {pr, pc} <= {reference_signal_in_i, comparator_in_i};
  sequence s_lead; !oe && ru && !cu; endsequence
  sequence s_lag; !oe && cu && !ru; endsequence
  xor_out_a: assert property (xor_detector_out_o == $past(reference_signal_in_i ^ comparator_in_i))
    else $error("xor");
  lock_lvl_a: assert property (lock_pulse_out_o == !oe) else $error("lock");
  up_start_a: assert property (s_lead |=> oe && pd) else $error("up");
  dn_start_a: assert property (s_lag |=> oe && !pd) else $error("dn");
  up_clear_a: assert property (oe && pd && cu && !ru |=> !oe) else $error("clr");
  dn_hold_a: assert property (oe && !pd && !ru |=> oe && !pd) else $error("hold");
  sr_set_a: assert property (ru |=> setreset_detector_out_o) else $error("set");
  sr_clr_a: assert property (cu && !ru |=> !setreset_detector_out_o) else $error("rst");
endmodule : pllpc_chk
bind pllpc_top pllpc_chk i_chk (.*);
`default_nettype wire

// ---- testbench/pllpc_src.sv ----
// Source model: even-duty square wave, idle low
`timescale 1ns/1ps
`default_nettype none
module pllpc_src (
  input wire logic clk_sys_i,
  input wire logic run_i,
  output logic sig_o
);
  logic [3:0] cnt;
  // Half period of 8 keeps duty at one half
  always_ff @(posedge clk_sys_i) begin
    cnt <= run_i ? cnt + 4'h1 : 4'h0;
    sig_o <= run_i & cnt[3];
  end
endmodule : pllpc_src
`default_nettype wire

// ---- testbench/pllpc_top_tb.sv ----
// Bench: phase detector and oscillator scenarios
`timescale 1ns/1ps
`default_nettype none
module pllpc_top_tb;
  logic clk_sys_i, rstn_i, reference_signal_in_i, comparator_in_i, oscillator_disable_i, run;
  logic [15:0] oscillator_control_in_i;
  logic xor_detector_out_o, edge_detector_tristate_out_o, edge_detector_tristate_oe_o;
  logic setreset_detector_out_o, lock_pulse_out_o, oscillator_out_o;
  int n_mismatch, n_compared, cyc;
  pllpc_top i_pllpc_top (.*);
  pllpc_src i_pllpc_src (.clk_sys_i, .run_i(run), .sig_o(reference_signal_in_i));
  task automatic chk(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask : chk
  // Outputs land on the edge that samples the pin, one edge after the drive
  task automatic cmp(input logic v);
    @(posedge clk_sys_i) comparator_in_i <= v;
    @(posedge clk_sys_i) #1;
  endtask : cmp
  task automatic t_phase;
    @(posedge clk_sys_i) run <= 1;
    @(posedge reference_signal_in_i);
    @(posedge clk_sys_i) #1;
    chk("xor", 1, xor_detector_out_o);
    chk("up", 1, edge_detector_tristate_out_o & edge_detector_tristate_oe_o);
    cmp(1);
    chk("lock", 1, lock_pulse_out_o & ~edge_detector_tristate_oe_o);
    chk("sr", 0, setreset_detector_out_o);
    cmp(0);
    @(negedge reference_signal_in_i);
    cmp(1);
    chk("dn", 0, edge_detector_tristate_out_o | ~edge_detector_tristate_oe_o);
    @(posedge clk_sys_i) run <= 0;
    repeat (20) @(posedge clk_sys_i) #1;
    chk("idle", 0, edge_detector_tristate_out_o | ~edge_detector_tristate_oe_o);
    $display("phase end");
  endtask : t_phase
  task automatic t_osc;
    @(posedge clk_sys_i) oscillator_disable_i <= 1;
    repeat (2) @(posedge clk_sys_i) #1;
    chk("off", 0, oscillator_out_o);
    @(posedge clk_sys_i) oscillator_disable_i <= 0;
    @(posedge oscillator_out_o);
    repeat (2) @(posedge clk_sys_i) #1;
    chk("hi", 1, oscillator_out_o);
    @(posedge clk_sys_i) #1;
    chk("lo", 0, oscillator_out_o);
    $display("osc end");
  endtask : t_osc
  // Loop closed through the comparator pin; control picks the faster side
  task automatic t_loop(input logic [15:0] half, input logic sig_fast);
    int n_hi = 0;
    int n_lo = 0;
    int n_off = 0;
    @(posedge clk_sys_i) begin
      run <= 1;
      oscillator_control_in_i <= half;
    end
    for (int i = 0; i < 192; i++) begin
      @(posedge clk_sys_i) comparator_in_i <= oscillator_out_o;
      if (i >= 96) begin
        if (edge_detector_tristate_oe_o !== 1'b1) n_off++;
        else if (edge_detector_tristate_out_o) n_hi++;
        else n_lo++;
      end
    end
    if (sig_fast) begin
      chk("fast_hi", 1, n_hi > n_off);
      chk("fast_off", 1, n_off > 0);
      chk("fast_lo", 0, n_lo > 0);
    end else begin
      chk("slow_lo", 1, n_lo > n_off);
      chk("slow_hi", 0, n_hi > 0);
    end
    $display("loop end");
  endtask : t_loop
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // Hang guard, far above the run length
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  initial forever #5 clk_sys_i = ~clk_sys_i;
  initial begin
    {clk_sys_i, rstn_i, comparator_in_i, oscillator_disable_i, run} = 5'h00;
    oscillator_control_in_i = 16'h0003;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1;
    t_phase;
    t_osc;
    t_loop(16'h0003, 1'b0);
    t_loop(16'h0018, 1'b1);
    report_and_stop;
  end
endmodule : pllpc_top_tb
`default_nettype wire
